// File: tb/ccr_ctrl_regs_bench.sv
// Self-checking bench of the converter control bank
`timescale 1ns/1ps
module ccr_ctrl_regs_bench;
   logic               clock = 1'b0;
   logic               rst = 1'b1;
   logic [3:0]         reg_address = 4'h0;
   logic               reg_read = 1'b0;
   logic               reg_write = 1'b0;
   logic [31:0]        reg_writedata = 32'h0;
   logic [31:0]        reg_readdata;
   logic               frame_start_req, frame_start_ack, frame_done, frame_active;
   logic [3:0]         shadow_index = 4'h0;
   logic signed [31:0] shadow_word;
   logic               go = 1'b0;
   int                 errors = 0;
   int                 n_compared = 0;
   always #2.5 clock = ~clock;
   ccr_ctrl_regs i_ccr_ctrl_regs (.clock(clock), .rst(rst), .reg_address(reg_address),
      .reg_read(reg_read), .reg_write(reg_write), .reg_writedata(reg_writedata),
      .reg_readdata(reg_readdata), .frame_start_req(frame_start_req),
      .frame_start_ack(frame_start_ack), .frame_done(frame_done),
      .shadow_index(shadow_index), .shadow_word(shadow_word), .frame_active(frame_active));
   ccr_datapath_model i_ccr_datapath_model (.clock(clock), .rst(rst), .go(go),
      .frame_start_req(frame_start_req), .frame_start_ack(frame_start_ack),
      .frame_done(frame_done));
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   task automatic step();
      @(posedge clock) #1;
   endtask : step
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      step();
      reg_address   = a;
      reg_writedata = d;
      reg_write     = 1'b1;
      step();
      reg_write = 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      step();
      reg_address = a;
      reg_read    = 1'b1;
      step();
      reg_read = 1'b0;
      check(reg_readdata, exp);
   endtask : rd
   task automatic rd_sh(input logic [3:0] k, input logic [31:0] exp);
      step();
      shadow_index = k;
      step();
      check(shadow_word, exp);
   endtask : rd_sh
   // Bounded wait, since a stuck sequencer must not hang the run
   task automatic wait_active(input logic v);
      for (int i = 0; i < 200 && frame_active !== v; i++)
         step();
      check({31'h0, frame_active}, {31'h0, v});
      if (frame_active !== v)
         finish_test();
   endtask : wait_active
   initial
   begin
      repeat (4) @(posedge clock);
      #1 rst = 1'b0;
      for (int a = 0; a < 16; a++)
         rd(4'(a), 32'h0);
      wr(4'h1, 32'h1);
      rd(4'h1, 32'h0);
      wr(4'h0, 32'hffff_ffff);
      rd(4'h0, 32'h1);
      rd(4'h1, 32'h1);
      for (int k = 0; k < 12; k++)
         wr(4'(k + 2), 32'hfff0_0000 + k);
      for (int k = 0; k < 12; k++)
         rd(4'(k + 2), 32'hfff0_0000 + k);
      rd(4'he, 32'h0);
      wr(4'hf, 32'hffff_ffff);
      rd(4'hf, 32'h0);
      go = 1'b1;
      wait_active(1'b1);
      go = 1'b0;
      for (int k = 0; k < 12; k++)
         wr(4'(k + 2), 32'h100 + k);
      rd(4'h1, 32'h1);
      for (int k = 0; k < 12; k++)
         rd_sh(4'(k), 32'hfff0_0000 + k);
      wait_active(1'b0);
      go = 1'b1;
      wait_active(1'b1);
      go = 1'b0;
      wr(4'h0, 32'h0);
      rd(4'h1, 32'h1);
      for (int k = 0; k < 12; k++)
         rd_sh(4'(k), 32'h100 + k);
      wait_active(1'b0);
      rd(4'h1, 32'h0);
      wr(4'h0, 32'h0);
      go = 1'b1;
      repeat (30) step();
      check({31'h0, frame_active}, 32'h0);
      rd(4'h1, 32'h0);
      go = 1'b0;
      finish_test();
   end
endmodule : ccr_ctrl_regs_bench

// File: tb/ccr_ctrl_regs_monitor.sv
// Port checker of the converter control bank
`timescale 1ns/1ps
module ccr_ctrl_regs_monitor #(
   parameter int unsigned DATA_W = 32
) (
   input wire logic              clock,
   input wire logic              rst,
   input wire logic [3:0]        reg_address,
   input wire logic              reg_read,
   input wire logic              reg_write,
   input wire logic [DATA_W-1:0] reg_writedata,
   input wire logic [DATA_W-1:0] reg_readdata,
   input wire logic              frame_start_req,
   input wire logic              frame_start_ack,
   input wire logic              frame_done,
   input wire logic [3:0]        shadow_index,
   input wire logic signed [DATA_W-1:0] shadow_word,
   input wire logic              frame_active
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_frame_open;
      frame_start_ack ##1 frame_active;
   endsequence
   a_ack_opens_frame: assert property (frame_start_ack |-> s_frame_open)
      else $error("ack without frame");
   a_ack_one_pulse: assert property (frame_start_ack |=> !frame_start_ack)
      else $error("ack longer than one cycle");
   a_frame_needs_ack: assert property ($rose(frame_active) |-> $past(frame_start_ack))
      else $error("frame opened without ack");
   a_frame_holds: assert property (frame_active && !frame_done |=> frame_active)
      else $error("frame ended early");
   a_done_closes: assert property (frame_active && frame_done |=> !frame_active)
      else $error("frame not closed");
   a_ctrl_upper_zero: assert property (reg_read && reg_address == 4'h0 |=> reg_readdata[31:1] == '0)
      else $error("control upper bits set");
   a_status_upper_zero: assert property (reg_read && reg_address == 4'h1 |=> reg_readdata[31:1] == '0)
      else $error("status upper bits set");
   a_unmapped_zero: assert property (reg_read && reg_address > 4'hd |=> reg_readdata == '0)
      else $error("unmapped read not zero");
   a_readdata_holds: assert property (!reg_read |=> $stable(reg_readdata))
      else $error("read data changed without read");
endmodule : ccr_ctrl_regs_monitor
bind ccr_ctrl_regs ccr_ctrl_regs_monitor #(.DATA_W(DATA_W)) i_ccr_ctrl_regs_monitor (
   .clock(clock), .rst(rst), .reg_address(reg_address), .reg_read(reg_read),
   .reg_write(reg_write), .reg_writedata(reg_writedata), .reg_readdata(reg_readdata),
   .frame_start_req(frame_start_req), .frame_start_ack(frame_start_ack),
   .frame_done(frame_done), .shadow_index(shadow_index), .shadow_word(shadow_word),
   .frame_active(frame_active));

// File: tb/ccr_datapath_model.sv
// Behavioural model of the pixel datapath that opens and closes frames
`timescale 1ns/1ps
module ccr_datapath_model #(
   parameter int unsigned LEN = 80
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Bench control
   input  wire logic go,
   // Frame handshake
   output logic      frame_start_req = 1'b0,
   input  wire logic frame_start_ack,
   output logic      frame_done = 1'b0
);
   int unsigned cnt = 0;
   // Request held until ack; only a withdrawn go drops it, to end a refused start
   always @(posedge clock)
   begin
      if (rst)
      begin
         frame_start_req <= 1'b0;
         frame_done      <= 1'b0;
         cnt             <= 0;
      end
      else
      begin
         frame_done <= (cnt == 1);
         if (frame_start_req)
         begin
            frame_start_req <= go && !frame_start_ack;
            cnt             <= frame_start_ack ? LEN : 0;
         end
         else if (cnt != 0)
            cnt <= cnt - 1;
         else
            frame_start_req <= go;
      end
   end
endmodule : ccr_datapath_model

// File: verilog/ccr_ctrl_regs.sv
// Run-time control register bank of the color space converter
// Functional notes
// - All control map registers are 32 bits
// - Coefficients and summands are signed two's complement
// - Registers sampled once at each frame start
// - Frame uses held copy, mid-frame writes ignored
// - Word 0 bit 0 is run/stop
// - Word 1 bit 0 shows status flag
// - Coefficients at words 2-10, summands 11-13
`timescale 1ns/1ps
module ccr_ctrl_regs #(
   parameter int unsigned DATA_W = ccr_pkg::DATA_W
) (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst,
   // Register port, word addressed
   input  wire logic [ccr_pkg::ADDR_W-1:0]  reg_address,
   input  wire logic                        reg_read,
   input  wire logic                        reg_write,
   input  wire logic [DATA_W-1:0]           reg_writedata,
   output logic      [DATA_W-1:0]           reg_readdata,
   // Frame handshake with the pixel datapath
   input  wire logic                        frame_start_req,
   output logic                             frame_start_ack,
   input  wire logic                        frame_done,
   // Per-frame conversion words to the datapath
   input  wire logic [3:0]                  shadow_index,
   output logic signed [DATA_W-1:0]         shadow_word,
   output logic                             frame_active
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // Refused at elaboration, since the map and the held copy are fixed at 32 bits
   if (DATA_W != 32)
   begin : g_width_check
      $error("ccr_ctrl_regs: DATA_W must be 32");
   end

   localparam int unsigned NWORDS = ccr_pkg::NUM_COEF + ccr_pkg::NUM_SUM;

   // ----------------------------------------------------------------
   // Software-visible registers
   // ----------------------------------------------------------------
   logic                    run_q, run_d;
   logic [DATA_W-1:0]       word_q [NWORDS];
   logic [DATA_W-1:0]       word_d [NWORDS];
   logic [DATA_W-1:0]       reg_readdata_d;
   logic                    status_flag;

   // Word n of the coefficient/summand array sits at word address n+2
   always_comb
   begin
      run_d = run_q;
      if (reg_write && (reg_address == ccr_pkg::RUN_CONTROL_ADDR))
      begin
         run_d = reg_writedata[ccr_pkg::RUN_BIT];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NWORDS; gi++)
      begin : g_word
         localparam logic [3:0] WADDR = ccr_pkg::COEF_ROW0_A_ADDR + 4'(gi);
         always_comb
         begin
            word_d[gi] = word_q[gi];
            if (reg_write && (reg_address == WADDR))
            begin
               word_d[gi] = reg_writedata;
            end
         end
         always_ff @(posedge clock)
         begin
            if (rst)
            begin
               word_q[gi] <= ccr_pkg::REG_RESET;
            end
            else
            begin
               word_q[gi] <= word_d[gi];
            end
         end
      end
   endgenerate

   // Status word is read-only; writes to it and to unmapped words are ignored
   always_comb
   begin
      reg_readdata_d = reg_readdata;
      if (reg_read)
      begin
         reg_readdata_d = '0;
         if (reg_address == ccr_pkg::RUN_CONTROL_ADDR)
         begin
            reg_readdata_d[ccr_pkg::RUN_BIT] = run_q;
         end
         else if (reg_address == ccr_pkg::RUN_STATUS_ADDR)
         begin
            reg_readdata_d[ccr_pkg::STATUS_BIT] = status_flag;
         end
         else if ((reg_address >= ccr_pkg::COEF_ROW0_A_ADDR) &&
                  (reg_address <= ccr_pkg::OFFSET_TERM_2_ADDR))
         begin
            reg_readdata_d = word_q[4'(reg_address - ccr_pkg::COEF_ROW0_A_ADDR)];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         run_q        <= 1'b0;
         reg_readdata <= '0;
      end
      else
      begin
         run_q        <= run_d;
         reg_readdata <= reg_readdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   // Run/stop is only looked at when a frame asks to start, so clearing it
   // mid-frame lets the current frame finish before the converter halts.
   ccr_pkg::ccr_state_t state_q, state_d;
   logic [3:0]          copy_cnt_q, copy_cnt_d;

   always_comb
   begin
      state_d    = state_q;
      copy_cnt_d = copy_cnt_q;
      case (state_q)
         ccr_pkg::CCR_IDLE:
         begin
            if (frame_start_req && run_q)
            begin
               state_d    = ccr_pkg::CCR_WAIT;
               copy_cnt_d = '0;
            end
         end
         ccr_pkg::CCR_WAIT:
         begin
            // Copy one word per cycle into the shadow memory
            if (32'(copy_cnt_q) == NWORDS - 1)
            begin
               state_d = ccr_pkg::CCR_FRAME;
            end
            else
            begin
               copy_cnt_d = copy_cnt_q + 4'h1;
            end
         end
         ccr_pkg::CCR_FRAME:
         begin
            if (frame_done)
            begin
               state_d = ccr_pkg::CCR_IDLE;
            end
         end
         default:
         begin
            state_d = ccr_pkg::CCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_q    <= ccr_pkg::CCR_IDLE;
         copy_cnt_q <= '0;
      end
      else
      begin
         state_q    <= state_d;
         copy_cnt_q <= copy_cnt_d;
      end
   end

   // Ack is combinational: high in the cycle the copy completes
   assign frame_start_ack = (state_q == ccr_pkg::CCR_WAIT) &&
                            (32'(copy_cnt_q) == NWORDS - 1);
   assign frame_active    = (state_q == ccr_pkg::CCR_FRAME);

   // Busy whenever run is set, and from the sampled start until the sequencer idles with run cleared
   assign status_flag = (state_q != ccr_pkg::CCR_IDLE) || run_q;

   // ----------------------------------------------------------------
   // Held per-frame copy
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem_rd;

   // Only written while copying, so bus writes in a frame cannot reach it
   ccr_shadow_mem #(
      .WIDTH (DATA_W),
      .DEPTH (NWORDS)
   ) u_shadow (
      .clock   (clock),
      .rst     (rst),
      .wr_en   (state_q == ccr_pkg::CCR_WAIT),
      .wr_addr (copy_cnt_q),
      .wr_data (word_q[copy_cnt_q]),
      .rd_addr (shadow_index),
      .rd_data (mem_rd)
   );

   assign shadow_word = signed'(mem_rd);
endmodule : ccr_ctrl_regs

// File: verilog/ccr_pkg.sv
// Package: register map, field positions and reset values of the converter control bank
package ccr_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned ADDR_W   = 4;
   localparam int unsigned NUM_REGS = 14;
   localparam int unsigned NUM_COEF = 9;
   localparam int unsigned NUM_SUM  = 3;

   // ----------------------------------------------------------------
   // Word addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] RUN_CONTROL_ADDR   = 4'h0;
   localparam logic [3:0] RUN_STATUS_ADDR    = 4'h1;
   localparam logic [3:0] COEF_ROW0_A_ADDR   = 4'h2;
   localparam logic [3:0] COEF_ROW0_B_ADDR   = 4'h3;
   localparam logic [3:0] COEF_ROW0_C_ADDR   = 4'h4;
   localparam logic [3:0] COEF_ROW1_A_ADDR   = 4'h5;
   localparam logic [3:0] COEF_ROW1_B_ADDR   = 4'h6;
   localparam logic [3:0] COEF_ROW1_C_ADDR   = 4'h7;
   localparam logic [3:0] COEF_ROW2_A_ADDR   = 4'h8;
   localparam logic [3:0] COEF_ROW2_B_ADDR   = 4'h9;
   localparam logic [3:0] COEF_ROW2_C_ADDR   = 4'ha;
   localparam logic [3:0] OFFSET_TERM_0_ADDR = 4'hb;
   localparam logic [3:0] OFFSET_TERM_1_ADDR = 4'hc;
   localparam logic [3:0] OFFSET_TERM_2_ADDR = 4'hd;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned RUN_BIT    = 0;
   localparam int unsigned STATUS_BIT = 0;
   localparam logic [31:0] REG_RESET  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CCR_IDLE  = 3'b001,
      CCR_FRAME = 3'b010,
      CCR_WAIT  = 3'b100
   } ccr_state_t;
endpackage : ccr_pkg

// File: verilog/ccr_shadow_mem.sv
// Small register-file memory holding the per-frame copy of the twelve conversion words
`timescale 1ns/1ps
module ccr_shadow_mem #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 12
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst,
   // Write side
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   // Read side, registered
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] rd_data_d;

   if (DEPTH < 2)
   begin : g_depth_check
      $error("ccr_shadow_mem: DEPTH must be at least 2");
   end

   always_comb
   begin
      rd_data_d = (32'(rd_addr) < DEPTH) ? mem_q[rd_addr] : '0;
   end

   always_ff @(posedge clock)
   begin
      if (wr_en && (32'(wr_addr) < DEPTH))
      begin
         mem_q[wr_addr] <= wr_data;
      end
      if (rst)
      begin
         rd_data <= '0;
      end
      else
      begin
         rd_data <= rd_data_d;
      end
   end
endmodule : ccr_shadow_mem
